//--- common/mmrs_pkg.sv
// Purpose: Shared constants and types for the module management block
// Assumes: Two-wire target sampled on ref_clk at 100 MHz
// Notes:   Named offsets and field positions live here; flag bit layout is in mmrs_mgmt

package mmrs_pkg;

  // ----------------------------------------------------------------
  // Bus addresses (7-bit form of the 8-bit addresses)
  // ----------------------------------------------------------------
  localparam logic [6:0] DEV_ID_MAP   = 7'h50;
  localparam logic [6:0] DEV_DIAG_MAP = 7'h51;

  // ----------------------------------------------------------------
  // Diagnostic map layout
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_TEMP_MSB  = 8'h60;
  localparam logic [7:0] OFS_TEMP_LSB  = 8'h61;
  localparam logic [7:0] OFS_VCC_MSB   = 8'h62;
  localparam logic [7:0] OFS_VCC_LSB   = 8'h63;
  localparam logic [7:0] OFS_BIAS_MSB  = 8'h64;
  localparam logic [7:0] OFS_BIAS_LSB  = 8'h65;
  localparam logic [7:0] OFS_TXP_MSB   = 8'h66;
  localparam logic [7:0] OFS_TXP_LSB   = 8'h67;
  localparam logic [7:0] OFS_RXP_MSB   = 8'h68;
  localparam logic [7:0] OFS_RXP_LSB   = 8'h69;
  localparam logic [7:0] OFS_RATE_A    = 8'h6E;
  localparam logic [7:0] OFS_ALARM     = 8'h70;
  localparam logic [7:0] OFS_WARN      = 8'h74;
  localparam logic [7:0] OFS_RATE_B    = 8'h76;
  localparam logic [7:0] OFS_USER_LO   = 8'h80;
  localparam logic [7:0] OFS_THR_BASE  = 8'h00;
  localparam logic [7:0] OFS_THR_LAST  = 8'h27;

  localparam int RS_SOFT_BIT = 3;
  localparam logic RS_SOFT_RESET = 1'b1;

  // Threshold block: per parameter 8 bytes hi_alarm, lo_alarm, hi_warn,
  // lo_warn (16 bits each, MSB first)
  localparam int THR_STRIDE = 8;
  localparam int NUM_MON    = 5;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MMRS_LOCK_8G5   = 2'h0,
    MMRS_LOCK_SPLIT = 2'h1,
    MMRS_LOCK_BYP   = 2'h2,
    MMRS_LOCK_10G   = 2'h3
  } mmrs_lock_e;

  typedef struct packed {
    logic [15:0] temp;
    logic [15:0] vcc;
    logic [15:0] bias;
    logic [15:0] tx_pwr;
    logic [15:0] rx_pwr;
  } mmrs_mon_s;

  typedef struct packed {
    logic tx_lock_8g5;
    logic tx_lock_10g;
    logic tx_bypass;
    logic rx_lock_8g5;
    logic rx_lock_10g;
    logic rx_bypass;
  } mmrs_cdr_s;

  typedef struct packed {
    logic       we;
    logic       sel_diag;
    logic [7:0] addr;
    logic [7:0] wdata;
  } mmrs_mem_req_s;

endpackage

//--- core/mmrs_mgmt.sv
// Purpose: Management logic of a pluggable optical module
// Assumes: ref_clk 100 MHz; host drives scl; pins arrive asynchronous
// Notes:   Identification map in RAM, diagnostics map with live values
//
// Notes on behaviour
// - Answer at address 1010000X with 256-byte map
// - Diagnostics map at 1010001X, identification unchanged
// - Capture on clock rise; skip protected segments
// - Launch read data on clock fall
// - Data line two-way; detect start and stop
// - Byte words, single or auto-incrementing access
// - Live temperature, bias, powers, supply readable
// - Alarm and warning flags outside set range
// - Effective rate select is pin OR soft bit
// - Both low: both units lock 8.5G
// - Low/high: transmit bypass, receive 10G
// - High/low: both units bypassed
// - Both high: both units lock 10G
// - Soft rate bits set to one at power-up
// - Undriven rate pins read low
// - Full operation straight after power-up
// - Low power: no traffic, management still active
// - Identification map readable, describes the module

`timescale 1ns/1ps

module mmrs_mgmt #(
  parameter bit LOW_POWER_START = 1'b0
) (
  input  wire logic                  ref_clk,
  input  wire logic                  rst,
  input  wire logic                  scl_in,
  input  wire logic                  sda_in,
  output logic                       sda_out,
  output logic                       sda_oe,
  input  wire logic                  rate_select_pin_first,
  input  wire logic                  rate_select_pin_second,
  input  wire mmrs_pkg::mmrs_mon_s   mon_in,
  input  wire logic                  low_power_req,
  output mmrs_pkg::mmrs_cdr_s        cdr_ctrl,
  output mmrs_pkg::mmrs_lock_e       lock_mode,
  output logic                       traffic_en,
  output logic                       alarm_any,
  output logic                       warn_any
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [4:0] sy1_reg;
  logic [4:0] sy2_reg;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sy1_reg <= 5'h03;
      sy2_reg <= 5'h03;
    end else begin
      sy1_reg <= {low_power_req, rate_select_pin_second,
                  rate_select_pin_first, sda_in, scl_in};
      sy2_reg <= sy1_reg;
    end
  end

  // Pull-down at the pin means a floating pin arrives as 0 here
  wire rs_first_s  = sy2_reg[2];
  wire rs_second_s = sy2_reg[3];
  wire lp_s        = sy2_reg[4];

  // ----------------------------------------------------------------
  // Serial target
  // ----------------------------------------------------------------
  mmrs_pkg::mmrs_mem_req_s req;
  logic                    req_vld;
  logic                    tgt_oe;
  logic [7:0]              rdata;
  logic [7:0]              rd_ptr;
  logic                    rd_diag;

  // Read data is picked at the target's pointer and map select
  mmrs_twi_target u_tgt (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .scl_s    (sy2_reg[0]),
    .sda_s    (sy2_reg[1]),
    .sda_oe   (tgt_oe),
    .req      (req),
    .req_vld  (req_vld),
    .ptr      (rd_ptr),
    .sel_diag (rd_diag),
    .rdata    (rdata)
  );

  // Open drain: pin only ever pulled low
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sda_out <= 1'b0;
      sda_oe  <= 1'b0;
    end else begin
      sda_out <= 1'b0;
      sda_oe  <= tgt_oe;
    end
  end

  // ----------------------------------------------------------------
  // Identification map
  // ----------------------------------------------------------------
  logic [7:0] id_mem [0:255];
  logic [7:0] id_rd;

  // Factory content left writable from the bus here; protection held
  // in the diagnostics map
  always_ff @(posedge ref_clk) begin
    if (req_vld && req.we && !req.sel_diag)
      id_mem[req.addr] <= req.wdata;
  end
  assign id_rd = id_mem[rd_ptr];

  // ----------------------------------------------------------------
  // Diagnostics map: thresholds, user area, control bytes
  // ----------------------------------------------------------------
  logic [7:0] diag_mem [0:255];
  logic       rs_soft_a_reg;
  logic       rs_soft_b_reg;

  function automatic logic diag_writable(input logic [7:0] a);
    diag_writable = (a <= mmrs_pkg::OFS_THR_LAST) ||
                    (a >= mmrs_pkg::OFS_USER_LO);
  endfunction

  always_ff @(posedge ref_clk) begin
    if (req_vld && req.we && req.sel_diag &&
        diag_writable(req.addr))
      diag_mem[req.addr] <= req.wdata;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rs_soft_a_reg <= mmrs_pkg::RS_SOFT_RESET;
      rs_soft_b_reg <= mmrs_pkg::RS_SOFT_RESET;
    end else if (req_vld && req.we && req.sel_diag) begin
      if (req.addr == mmrs_pkg::OFS_RATE_A)
        rs_soft_a_reg <= req.wdata[mmrs_pkg::RS_SOFT_BIT];
      if (req.addr == mmrs_pkg::OFS_RATE_B)
        rs_soft_b_reg <= req.wdata[mmrs_pkg::RS_SOFT_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Monitor capture and range checks
  // ----------------------------------------------------------------
  mmrs_pkg::mmrs_mon_s mon_reg;
  logic [15:0]         mon_w [0:mmrs_pkg::NUM_MON-1];
  logic [7:0]          alarm_reg;
  logic [7:0]          warn_reg;

  always_ff @(posedge ref_clk) begin
    if (rst) mon_reg <= '0;
    else     mon_reg <= mon_in;
  end

  assign mon_w[0] = mon_reg.temp;
  assign mon_w[1] = mon_reg.vcc;
  assign mon_w[2] = mon_reg.bias;
  assign mon_w[3] = mon_reg.tx_pwr;
  assign mon_w[4] = mon_reg.rx_pwr;

  function automatic logic [15:0] thr(input int p, input int k);
    thr = {diag_mem[8'(p * mmrs_pkg::THR_STRIDE + 2 * k)],
           diag_mem[8'(p * mmrs_pkg::THR_STRIDE + 2 * k + 1)]};
  endfunction

  // Flags laid out high-bit first: temp hi, temp lo, vcc hi, ...
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      alarm_reg <= 8'h00;
      warn_reg  <= 8'h00;
    end else begin
      for (int p = 0; p < 4; p++) begin
        alarm_reg[7-2*p] <= (mon_w[p] > thr(p, 0));
        alarm_reg[6-2*p] <= (mon_w[p] < thr(p, 1));
        warn_reg[7-2*p]  <= (mon_w[p] > thr(p, 2));
        warn_reg[6-2*p]  <= (mon_w[p] < thr(p, 3));
      end
    end
  end

  logic [1:0] rx_alarm_reg;
  logic [1:0] rx_warn_reg;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rx_alarm_reg <= 2'h0;
      rx_warn_reg  <= 2'h0;
    end else begin
      rx_alarm_reg <= {mon_w[4] > thr(4, 0), mon_w[4] < thr(4, 1)};
      rx_warn_reg  <= {mon_w[4] > thr(4, 2), mon_w[4] < thr(4, 3)};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      alarm_any <= 1'b0;
      warn_any  <= 1'b0;
    end else begin
      alarm_any <= |{alarm_reg, rx_alarm_reg};
      warn_any  <= |{warn_reg, rx_warn_reg};
    end
  end

  // ----------------------------------------------------------------
  // Diagnostic read mux
  // ----------------------------------------------------------------
  logic [7:0] diag_rd;

  always_comb begin
    case (rd_ptr)
      mmrs_pkg::OFS_TEMP_MSB: diag_rd = mon_reg.temp[15:8];
      mmrs_pkg::OFS_TEMP_LSB: diag_rd = mon_reg.temp[7:0];
      mmrs_pkg::OFS_VCC_MSB:  diag_rd = mon_reg.vcc[15:8];
      mmrs_pkg::OFS_VCC_LSB:  diag_rd = mon_reg.vcc[7:0];
      mmrs_pkg::OFS_BIAS_MSB: diag_rd = mon_reg.bias[15:8];
      mmrs_pkg::OFS_BIAS_LSB: diag_rd = mon_reg.bias[7:0];
      mmrs_pkg::OFS_TXP_MSB:  diag_rd = mon_reg.tx_pwr[15:8];
      mmrs_pkg::OFS_TXP_LSB:  diag_rd = mon_reg.tx_pwr[7:0];
      mmrs_pkg::OFS_RXP_MSB:  diag_rd = mon_reg.rx_pwr[15:8];
      mmrs_pkg::OFS_RXP_LSB:  diag_rd = mon_reg.rx_pwr[7:0];
      mmrs_pkg::OFS_RATE_A:
        diag_rd = 8'(rs_soft_a_reg) << mmrs_pkg::RS_SOFT_BIT;
      mmrs_pkg::OFS_RATE_B:
        diag_rd = 8'(rs_soft_b_reg) << mmrs_pkg::RS_SOFT_BIT;
      mmrs_pkg::OFS_ALARM:    diag_rd = alarm_reg;
      mmrs_pkg::OFS_ALARM + 8'h01: diag_rd = {rx_alarm_reg, 6'h00};
      mmrs_pkg::OFS_WARN:     diag_rd = warn_reg;
      mmrs_pkg::OFS_WARN + 8'h01:  diag_rd = {rx_warn_reg, 6'h00};
      default:                diag_rd = diag_mem[rd_ptr];
    endcase
  end

  assign rdata = rd_diag ? diag_rd : id_rd;

  // ----------------------------------------------------------------
  // Clock recovery mode and power level
  // ----------------------------------------------------------------
  mmrs_rate_decode u_rate (
    .ref_clk     (ref_clk),
    .rst         (rst),
    .pin_first   (rs_first_s),
    .pin_second  (rs_second_s),
    .soft_first  (rs_soft_a_reg),
    .soft_second (rs_soft_b_reg),
    .mode        (lock_mode),
    .clock_recovery_unit         (cdr_ctrl)
  );

  // Management path is independent of this, so it keeps running
  always_ff @(posedge ref_clk) begin
    if (rst) traffic_en <= 1'b0;
    else     traffic_en <= ~(LOW_POWER_START & lp_s);
  end

endmodule

//--- core/mmrs_rate_decode.sv
// Purpose: Clock recovery locking mode decode from rate selects
// Assumes: Pins synchronised, soft bits from the diagnostic map
// Notes:   Outputs registered

`timescale 1ns/1ps

module mmrs_rate_decode (
  input  wire logic              ref_clk,
  input  wire logic              rst,
  input  wire logic              pin_first,
  input  wire logic              pin_second,
  input  wire logic              soft_first,
  input  wire logic              soft_second,
  output mmrs_pkg::mmrs_lock_e   mode,
  output mmrs_pkg::mmrs_cdr_s    clock_recovery_unit
);

  logic eff_first;
  logic eff_second;
  assign eff_first  = pin_first | soft_first;
  assign eff_second = pin_second | soft_second;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mode <= mmrs_pkg::MMRS_LOCK_10G;
      clock_recovery_unit  <= '{tx_lock_10g: 1'b1, rx_lock_10g: 1'b1, default: 1'b0};
    end else begin
      clock_recovery_unit <= '0;
      case ({eff_first, eff_second})
        2'b00: begin
          mode <= mmrs_pkg::MMRS_LOCK_8G5;
          clock_recovery_unit  <= '{tx_lock_8g5: 1'b1, rx_lock_8g5: 1'b1,
                    default: 1'b0};
        end
        2'b01: begin
          mode <= mmrs_pkg::MMRS_LOCK_SPLIT;
          clock_recovery_unit  <= '{tx_bypass: 1'b1, rx_lock_10g: 1'b1,
                    default: 1'b0};
        end
        2'b10: begin
          mode <= mmrs_pkg::MMRS_LOCK_BYP;
          clock_recovery_unit  <= '{tx_bypass: 1'b1, rx_bypass: 1'b1,
                    default: 1'b0};
        end
        default: begin
          mode <= mmrs_pkg::MMRS_LOCK_10G;
          clock_recovery_unit  <= '{tx_lock_10g: 1'b1, rx_lock_10g: 1'b1,
                    default: 1'b0};
        end
      endcase
    end
  end

endmodule

//--- core/mmrs_twi_target.sv
// Purpose: Two-wire serial target, byte engine with address pointer
// Assumes: Pins already synchronised; scl edges found on ref_clk
// Notes:   Answers two device addresses, auto-increments the pointer

`timescale 1ns/1ps

module mmrs_twi_target (
  input  wire logic                  ref_clk,
  input  wire logic                  rst,
  input  wire logic                  scl_s,
  input  wire logic                  sda_s,
  output logic                       sda_oe,
  output mmrs_pkg::mmrs_mem_req_s    req,
  output logic                       req_vld,
  output logic [7:0]                 ptr,
  output logic                       sel_diag,
  input  wire logic [7:0]            rdata
);

  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_DEV  = 6'b000010,
    ST_ACK  = 6'b000100,
    ST_WR   = 6'b001000,
    ST_RD   = 6'b010000,
    ST_RACK = 6'b100000
  } mmrs_tst_e;

  mmrs_tst_e   st_reg;
  logic        scl_d_reg;
  logic        sda_d_reg;
  logic [7:0]  sh_reg;
  logic [3:0]  cnt_reg;
  logic [7:0]  ptr_reg;
  logic        diag_reg;
  logic        rd_reg;
  logic        ptr_set_reg;
  logic        ack_pend_reg;

  wire scl_rise = scl_s & ~scl_d_reg;
  wire scl_fall = ~scl_s & scl_d_reg;
  // Start and stop: data moves while clock is high
  wire start_c = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  wire stop_c  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

  function automatic logic addr_hit(input logic [6:0] a);
    addr_hit = (a == mmrs_pkg::DEV_ID_MAP) ||
               (a == mmrs_pkg::DEV_DIAG_MAP);
  endfunction

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_reg       <= ST_IDLE;
      sh_reg       <= 8'h00;
      cnt_reg      <= 4'h0;
      ptr_reg      <= 8'h00;
      diag_reg     <= 1'b0;
      rd_reg       <= 1'b0;
      ptr_set_reg  <= 1'b0;
      ack_pend_reg <= 1'b0;
      sda_oe       <= 1'b0;
      req          <= '0;
      req_vld      <= 1'b0;
    end else begin
      req_vld <= 1'b0;
      if (stop_c) begin
        st_reg <= ST_IDLE;
        sda_oe <= 1'b0;
      end else if (start_c) begin
        st_reg  <= ST_DEV;
        cnt_reg <= 4'h0;
        sda_oe  <= 1'b0;
      end else begin
        case (st_reg)
          ST_IDLE: sda_oe <= 1'b0;
          ST_DEV, ST_WR: begin
            if (scl_rise) begin
              sh_reg  <= {sh_reg[6:0], sda_s};
              cnt_reg <= cnt_reg + 4'h1;
            end
            if (scl_fall && cnt_reg == 4'h8) begin
              cnt_reg <= 4'h0;
              if (st_reg == ST_DEV) begin
                if (addr_hit(sh_reg[7:1])) begin
                  diag_reg    <= (sh_reg[7:1] == mmrs_pkg::DEV_DIAG_MAP);
                  rd_reg      <= sh_reg[0];
                  ptr_set_reg <= 1'b0;
                  sda_oe      <= 1'b1;
                  st_reg      <= ST_ACK;
                end else begin
                  st_reg <= ST_IDLE;
                end
              end else begin
                if (!ptr_set_reg) begin
                  ptr_reg     <= sh_reg;
                  ptr_set_reg <= 1'b1;
                end else begin
                  // Protection decided by the map owner; bus still acks
                  req     <= '{we: 1'b1, sel_diag: diag_reg,
                               addr: ptr_reg, wdata: sh_reg};
                  req_vld <= 1'b1;
                  ptr_reg <= ptr_reg + 8'h01;
                end
                sda_oe <= 1'b1;
                st_reg <= ST_ACK;
              end
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              if (rd_reg) begin
                sh_reg  <= rdata;
                sda_oe  <= ~rdata[7];
                cnt_reg <= 4'h1;
                ptr_reg <= ptr_reg + 8'h01;
                st_reg  <= ST_RD;
              end else begin
                sda_oe <= 1'b0;
                st_reg <= ST_WR;
              end
            end
          end
          ST_RD: begin
            if (scl_fall) begin
              if (cnt_reg == 4'h8) begin
                sda_oe  <= 1'b0;
                cnt_reg <= 4'h0;
                st_reg  <= ST_RACK;
              end else begin
                sda_oe  <= ~sh_reg[6];
                sh_reg  <= {sh_reg[6:0], 1'b0};
                cnt_reg <= cnt_reg + 4'h1;
              end
            end
          end
          ST_RACK: begin
            if (scl_rise) ack_pend_reg <= ~sda_s;
            if (scl_fall) begin
              if (ack_pend_reg) begin
                sh_reg  <= rdata;
                sda_oe  <= ~rdata[7];
                cnt_reg <= 4'h1;
                ptr_reg <= ptr_reg + 8'h01;
                st_reg  <= ST_RD;
              end else begin
                st_reg <= ST_IDLE;
              end
            end
          end
          default: st_reg <= ST_IDLE;
        endcase
      end
    end
  end

  // Read data comes from the current pointer, before it advances
  assign ptr      = ptr_reg;
  assign sel_diag = diag_reg;

endmodule

//--- tb/mmrs_host_model.sv
// Purpose: Host side two-wire controller model
// Assumes: Pull-up on the data line, 160 ns serial clock
// Notes:   Serial clock idles high between frames
`timescale 1ns/1ps
module mmrs_host_model (
  input  wire logic ref_clk,
  input  wire logic sda_line,
  output logic      scl,
  output logic      sda_pull
);
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  // Releases sda first, so it also serves as a repeated start
  task automatic start();
    sda_pull = 1'b0;
    wt(8);
    scl = 1'b1;
    wt(8);
    sda_pull = 1'b1;
    wt(8);
    scl = 1'b0;
  endtask
  task automatic stop();
    wt(4);
    sda_pull = 1'b1;
    wt(4);
    scl = 1'b1;
    wt(8);
    sda_pull = 1'b0;
    wt(8);
  endtask
  // Data moves mid low phase, away from both scl edges
  task automatic bit_io(input logic b, output logic s);
    wt(4);
    sda_pull = !b;
    wt(4);
    scl = 1'b1;
    wt(6);
    s = sda_line;
    wt(2);
    scl = 1'b0;
  endtask
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(d[i], s);
    bit_io(1'b1, s);
    ack = !s;
  endtask
  task automatic rd_byte(output logic [7:0] d, input logic last);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(last, s);
  endtask
endmodule

//--- tb/mmrs_mgmt_bench.sv
// Purpose: Self-checking bench for the module management block
// Assumes: Host model makes scl; data line has a pull-up
// Notes:   Monitor values from a fixed-seed shift register
`timescale 1ns/1ps
module mmrs_mgmt_bench;
  logic                 ref_clk = 1'b0;
  logic                 rst, scl_in, sda_in, sda_out, sda_oe, sda_pull;
  logic                 rate_select_pin_first, rate_select_pin_second;
  logic                 low_power_req, traffic_en, alarm_any, warn_any, ack;
  mmrs_pkg::mmrs_mon_s  mon_in;
  mmrs_pkg::mmrs_cdr_s  cdr_ctrl;
  mmrs_pkg::mmrs_lock_e lock_mode;
  logic [7:0]           wbuf [64];
  logic [7:0]           rbuf [16];
  logic [31:0]          seed = 32'h0001_4713;
  int                   n_fail = 0;
  int                   comparisons = 0;
  always #5 ref_clk = ~ref_clk;
  assign sda_in = !((sda_oe && !sda_out) || sda_pull);
  mmrs_mgmt #(.LOW_POWER_START(1'b1)) uut (.*);
  mmrs_host_model host (
    .ref_clk  (ref_clk),
    .sda_line (sda_in),
    .scl      (scl_in),
    .sda_pull (sda_pull)
  );
  function automatic logic [7:0] rnd();
    repeat (8) seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[7:0];
  endfunction
  function automatic logic [5:0] cdr_of(input logic [1:0] m);
    return {m == 2'h0, &m, ^m, m == 2'h0, m[0], m == 2'h2};
  endfunction
  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic conclude();
    if (n_fail == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [6:0] dev, input logic [7:0] ptr,
                    input int b, input int n);
    logic a;
    host.start();
    host.wr_byte({dev, 1'b0}, a);
    chk("address ack", 16'h0001, 16'(a));
    host.wr_byte(ptr, a);
    for (int i = 0; i < n; i++) begin
      host.wr_byte(wbuf[b + i], a);
      chk("data ack", 16'h0001, 16'(a));
    end
    host.stop();
    repeat (8) @(negedge ref_clk);
  endtask
  task automatic rd(input logic [6:0] dev, input logic [7:0] ptr,
                    input int n);
    logic a;
    host.start();
    host.wr_byte({dev, 1'b0}, a);
    host.wr_byte(ptr, a);
    host.start();
    host.wr_byte({dev, 1'b1}, a);
    chk("read ack", 16'h0001, 16'(a));
    for (int i = 0; i < n; i++) host.rd_byte(rbuf[i], i == n - 1);
    host.stop();
  endtask
  initial begin
    #900000;
    n_fail++;
    conclude();
  end
  initial begin
    rst = 1'b1;
    {rate_select_pin_first, rate_select_pin_second} = 2'h0;
    low_power_req = 1'b0;
    mon_in = '0;
    repeat (8) @(negedge ref_clk);
    rst = 1'b0;
    repeat (4) @(negedge ref_clk);
    chk("lock_mode", 16'h0003, 16'(lock_mode));
    chk("cdr_ctrl", 16'h0012, 16'(cdr_ctrl));
    chk("traffic_en", 16'h0001, 16'(traffic_en));
    host.start();
    host.wr_byte(8'hA4, ack);
    chk("foreign ack", 16'h0000, 16'(ack));
    host.stop();
    wbuf[0] = rnd();
    wbuf[1] = rnd();
    wbuf[2] = ~wbuf[0];
    wbuf[3] = 8'h00;
    wbuf[4] = 8'hFF;
    wbuf[5] = 8'h08;
    wbuf[6] = 8'h80;
    // Pointer wraps from the top of the map
    wr(mmrs_pkg::DEV_ID_MAP, 8'hFF, 0, 2);
    wr(mmrs_pkg::DEV_DIAG_MAP, mmrs_pkg::OFS_USER_LO, 2, 1);
    rd(mmrs_pkg::DEV_ID_MAP, 8'hFF, 2);
    chk("id byte", 16'(wbuf[0]), 16'(rbuf[0]));
    chk("id next", 16'(wbuf[1]), 16'(rbuf[1]));
    rd(mmrs_pkg::DEV_DIAG_MAP, mmrs_pkg::OFS_USER_LO, 1);
    chk("user byte", 16'(wbuf[2]), 16'(rbuf[0]));
    wr(mmrs_pkg::DEV_DIAG_MAP, mmrs_pkg::OFS_RATE_A, 3, 1);
    wr(mmrs_pkg::DEV_DIAG_MAP, mmrs_pkg::OFS_RATE_B, 3, 1);
    for (int k = 0; k < 4; k++) begin
      {rate_select_pin_first, rate_select_pin_second} = 2'(k);
      repeat (8) @(negedge ref_clk);
      chk("lock_mode", 16'(k), 16'(lock_mode));
      chk("cdr_ctrl", 16'(cdr_of(2'(k))), 16'(cdr_ctrl));
    end
    {rate_select_pin_first, rate_select_pin_second} = 2'h0;
    wr(mmrs_pkg::DEV_DIAG_MAP, mmrs_pkg::OFS_RATE_A, 4, 1);
    chk("lock_mode", 16'h0002, 16'(lock_mode));
    wr(mmrs_pkg::DEV_DIAG_MAP, mmrs_pkg::OFS_RATE_B, 5, 1);
    chk("lock_mode", 16'h0003, 16'(lock_mode));
    rd(mmrs_pkg::DEV_DIAG_MAP, mmrs_pkg::OFS_RATE_A, 1);
    chk("soft byte", 16'h0008, 16'(rbuf[0]));
    low_power_req = 1'b1;
    // Kept positive and nonzero so threshold outcomes are known
    for (int f = 0; f < 5; f++)
      mon_in[79 - 16 * f -: 16] = {2'h1, 6'(rnd()), rnd()};
    rd(mmrs_pkg::DEV_DIAG_MAP, mmrs_pkg::OFS_TEMP_MSB, 10);
    for (int i = 0; i < 10; i++)
      chk("monitor", 16'(mon_in[79 - 8 * i -: 8]), 16'(rbuf[i]));
    wr(mmrs_pkg::DEV_DIAG_MAP, mmrs_pkg::OFS_TEMP_MSB, 6, 1);
    rd(mmrs_pkg::DEV_DIAG_MAP, mmrs_pkg::OFS_TEMP_MSB, 1);
    chk("protected", 16'(mon_in[79:72]), 16'(rbuf[0]));
    chk("traffic_en", 16'h0000, 16'(traffic_en));
    low_power_req = 1'b0;
    for (int i = 0; i < 40; i++) wbuf[8 + i] = i[1] ? 8'h00 : 8'hFF;
    wbuf[48] = 8'h00;
    wbuf[49] = 8'h00;
    wr(mmrs_pkg::DEV_DIAG_MAP, mmrs_pkg::OFS_THR_BASE, 8, 40);
    chk("alarm_any", 16'h0000, 16'(alarm_any));
    chk("warn_any", 16'h0000, 16'(warn_any));
    wr(mmrs_pkg::DEV_DIAG_MAP, 8'h00, 48, 2);
    chk("alarm_any", 16'h0001, 16'(alarm_any));
    chk("warn_any", 16'h0000, 16'(warn_any));
    wr(mmrs_pkg::DEV_DIAG_MAP, 8'h04, 48, 2);
    chk("warn_any", 16'h0001, 16'(warn_any));
    chk("traffic_en", 16'h0001, 16'(traffic_en));
    conclude();
  end
endmodule

//--- tb/mmrs_mgmt_checker.sv
// Purpose: Port assertions for the module management block
// Assumes: One ref_clk domain, rst synchronous active high
// Notes:   Bound to every mmrs_mgmt instance
`timescale 1ns/1ps
module mmrs_mgmt_checker #(
  parameter bit LOW_POWER_START = 1'b0
) (
  input wire logic                 ref_clk,
  input wire logic                 rst,
  input wire logic                 scl_in,
  input wire logic                 sda_out,
  input wire logic                 sda_oe,
  input wire logic                 rate_select_pin_first,
  input wire logic                 rate_select_pin_second,
  input wire logic                 low_power_req,
  input wire mmrs_pkg::mmrs_cdr_s  cdr_ctrl,
  input wire mmrs_pkg::mmrs_lock_e lock_mode,
  input wire logic                 traffic_en
);
  // ----------------------------------------------------------------
  // Helpers and assertions
  // ----------------------------------------------------------------
  logic [5:0] cdr_exp;
  logic [4:0] hi_cnt;
  always_comb begin
    case (lock_mode)
      mmrs_pkg::MMRS_LOCK_8G5:   cdr_exp = 6'h24;
      mmrs_pkg::MMRS_LOCK_SPLIT: cdr_exp = 6'h0A;
      mmrs_pkg::MMRS_LOCK_BYP:   cdr_exp = 6'h09;
      default:                   cdr_exp = 6'h12;
    endcase
  end
  // Long scl high means idle; one bit keeps it high only 8 cycles
  always_ff @(posedge ref_clk) begin
    if (rst || !scl_in) hi_cnt <= 5'h00;
    else if (hi_cnt != 5'h1F) hi_cnt <= hi_cnt + 5'h01;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  chk_open_drain: assert property (
    sda_out == 1'b0) else $error("sda_out not low");
  chk_oe_scl_low: assert property (
    $changed(sda_oe) |-> !scl_in) else $error("sda_oe moved, scl high");
  chk_reset_mode: assert property (
    $past(rst) |-> lock_mode == mmrs_pkg::MMRS_LOCK_10G)
    else $error("mode not 10G after reset");
  chk_mode_cdr: assert property (
    cdr_ctrl == cdr_exp) else $error("cdr_ctrl disagrees with mode");
  chk_first_or: assert property (
    rate_select_pin_first [*6] |-> lock_mode[1])
    else $error("first pin not in mode");
  chk_second_or: assert property (
    rate_select_pin_second [*6] |-> lock_mode[0])
    else $error("second pin not in mode");
  chk_traffic_up: assert property (
    !$past(rst, 3) |->
      traffic_en == !(LOW_POWER_START && $past(low_power_req, 3)))
    else $error("traffic_en disagrees with power level");
  chk_idle_release: assert property (
    hi_cnt > 5'h0C |-> !sda_oe) else $error("sda held on idle bus");
endmodule
bind mmrs_mgmt mmrs_mgmt_checker #(.LOW_POWER_START(LOW_POWER_START))
  u_chk (.*);
